//--- design/rtr_defines.svh
`ifndef RTR_DEFINES_SVH
`define RTR_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RTR_OFS_ROUTE0 8'h00
`define RTR_OFS_ROUTE1 8'h04
`define RTR_OFS_ROUTE2 8'h08
`define RTR_OFS_PWMSEL0 8'h0C
`define RTR_OFS_PWMSEL1 8'h10
`define RTR_OFS_GSEL1 8'h14
`define RTR_OFS_GSEL2 8'h18
`define RTR_OFS_STATUS 8'h1C
`define RTR_OFS_ACTIVITY 8'h20

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTR_RST_ROUTE0 32'h0000_0001
`define RTR_RST_ZERO 32'h0000_0000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RTR_DEF_BIT 0
`define RTR_ALT_BIT 1
// option A bit of each switchable event; option B bit sits one above
`define RTR_C1_E2_POS 8
`define RTR_C1_E4_POS 16
`define RTR_C1_E6_POS 24
`define RTR_C1_E7_POS 0
`define RTR_C1_E8_POS 8
`define RTR_C2_E2_POS 16
`define RTR_C2_E4_POS 24
`define RTR_C2_E6_POS 0
`define RTR_C2_E7_POS 8
`define RTR_C2_E8_POS 16
// pwm A route select bits: modules 1..4 in word 0, 5..7 in word 1
`define RTR_PWM_SEL_P0 0
`define RTR_PWM_SEL_P1 8
`define RTR_PWM_SEL_P2 16
`define RTR_PWM_SEL_P3 24
// group trigger select fields
`define RTR_GSEL_EV_LSB 0
`define RTR_GSEL_G1_LSB 8
`define RTR_GSEL_G2_LSB 16
`define RTR_GSEL_W 3
// status and activity layout
`define RTR_STAT_C1_LSB 0
`define RTR_STAT_C2_LSB 3
`define RTR_STAT_PWM_LSB 6
`define RTR_STAT_W 10

`endif

//--- design/rtr_pkg.sv
package rtr_pkg;

	typedef struct packed {
		logic [31:0] timer1_channels;
		logic [17:0] timer2_channels;
		logic rti_compare0;
		logic [1:0] port_b_bits;
	} rtr_src_t;

	typedef struct packed {
		logic combined_b_trigger;
		logic combined_a1_trigger;
		logic combined_a2_trigger;
		logic combined_ab_trigger;
	} rtr_pwm_trig_t;

	// opt_a / opt_b index 0..4 stands for events 2, 4, 6, 7, 8
	typedef struct packed {
		logic default_en;
		logic alt_en;
		logic [4:0] opt_a;
		logic [4:0] opt_b;
	} rtr_route_t;

	typedef struct packed {
		logic [2:0] group2_trigger_sel;
		logic [2:0] group1_trigger_sel;
		logic [2:0] event_group_trigger_sel;
	} rtr_grp_sel_t;

endpackage

//--- design/rtr_pwm_combine.sv
`timescale 1ns/10ps
module rtr_pwm_combine
	import rtr_pkg::*;
#(
	parameter int NUM_PWM = 7
) (
	input wire logic [NUM_PWM-1:0] pwm_conv_start_a_in,
	input wire logic [NUM_PWM-1:0] pwm_conv_start_b_in,
	input wire logic [NUM_PWM-1:0] pwm_a_route_select_in,
	output rtr_pwm_trig_t comb_out
);

	logic b_any;
	logic a1_any;
	logic a2_any;

	assign b_any = |pwm_conv_start_b_in;
	assign a1_any = |(pwm_conv_start_a_in & ~pwm_a_route_select_in);
	assign a2_any = |(pwm_conv_start_a_in & pwm_a_route_select_in);

	// no storage: a start pulse reaches the converter in the same cycle
	always_comb begin
		comb_out.combined_b_trigger = b_any;
		comb_out.combined_a1_trigger = a1_any;
		comb_out.combined_a2_trigger = a2_any;
		comb_out.combined_ab_trigger = b_any | a2_any;
	end

endmodule // rtr_pwm_combine

//--- design/rtr_conv_select.sv
`timescale 1ns/10ps
module rtr_conv_select
	import rtr_pkg::*;
(
	input wire logic event_pad_in,
	input wire rtr_src_t src_in,
	input wire rtr_pwm_trig_t pwm_in,
	input wire rtr_route_t route_in,
	input wire rtr_grp_sel_t sel_in,
	output logic [2:0] group_trig_out
);

	logic [7:0] ev;

	// a switchable event with neither option bit set delivers nothing
	function automatic logic pick_opt(input logic a_en, input logic b_en,
		input logic a_src, input logic b_src);
		if (a_en) begin
			return a_src;
		end else if (b_en) begin
			return b_src;
		end
		return 1'b0;
	endfunction

	function automatic logic pick_event(input logic [7:0] evs, input logic [2:0] code);
		return evs[code];
	endfunction

	// ------------------------------------------------------------
	// event table, ev[0] is event 1
	// ------------------------------------------------------------
	always_comb begin
		ev = 8'h00;
		if (route_in.default_en) begin
			ev[0] = event_pad_in;
			ev[1] = src_in.timer1_channels[8];
			ev[2] = src_in.timer1_channels[10];
			ev[3] = src_in.rti_compare0;
			ev[4] = src_in.timer1_channels[12];
			ev[5] = src_in.timer1_channels[14];
			ev[6] = src_in.port_b_bits[0];
			ev[7] = src_in.port_b_bits[1];
		end else if (route_in.alt_en) begin
			ev[0] = event_pad_in;
			ev[2] = src_in.timer1_channels[27];
			ev[4] = src_in.timer1_channels[17];
			ev[1] = pick_opt(route_in.opt_a[0], route_in.opt_b[0],
				src_in.timer2_channels[5], pwm_in.combined_b_trigger);
			ev[3] = pick_opt(route_in.opt_a[1], route_in.opt_b[1],
				src_in.rti_compare0, pwm_in.combined_a1_trigger);
			ev[5] = pick_opt(route_in.opt_a[2], route_in.opt_b[2],
				src_in.timer1_channels[19], src_in.timer2_channels[1]);
			ev[6] = pick_opt(route_in.opt_a[3], route_in.opt_b[3],
				src_in.timer1_channels[11], pwm_in.combined_a2_trigger);
			ev[7] = pick_opt(route_in.opt_a[4], route_in.opt_b[4],
				src_in.timer2_channels[13], pwm_in.combined_ab_trigger);
		end
	end

	always_comb begin
		group_trig_out[0] = pick_event(ev, sel_in.event_group_trigger_sel);
		group_trig_out[1] = pick_event(ev, sel_in.group1_trigger_sel);
		group_trig_out[2] = pick_event(ev, sel_in.group2_trigger_sel);
	end

endmodule // rtr_conv_select

//--- design/rtr_router.sv
// Contract
// - three groups, each picks one of eight
// - select codes 000..111 give events 1..8
// - default bit set gives default source set
// - alternate set: events 1,3,5 fixed sources
// - events 2,4,6,7,8 choose option A or B
// - converter 2 mirrors converter 1, own bits
// - pad triggers tapped after input buffer
// - timer and pwm triggers come straight from modules
// - real-time compare taken before interrupt gating
// - each pwm A start has own select bit
// - combined B is OR of B starts
// - combined A1 ORs A starts, select clear
// - combined A2 ORs A starts, select set
// - combined AB is B OR A2
`timescale 1ns/10ps
`include "rtr_defines.svh"
module rtr_router
	import rtr_pkg::*;
#(
	parameter int NUM_PWM = 7
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic conv1_event_pad_in,
	input wire logic conv2_event_pad_in,
	input wire logic [31:0] timer1_channels_in,
	input wire logic [17:0] timer2_channels_in,
	input wire logic rti_compare0_in,
	input wire logic [1:0] port_b_bits_in,
	input wire logic [NUM_PWM-1:0] pwm_conv_start_a_in,
	input wire logic [NUM_PWM-1:0] pwm_conv_start_b_in,
	output logic [2:0] conv1_group_trig_out,
	output logic [2:0] conv2_group_trig_out
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [31:0] route0_q;
	logic [31:0] route1_q;
	logic [31:0] route2_q;
	logic [31:0] pwmsel0_q;
	logic [31:0] pwmsel1_q;
	logic [31:0] gsel1_q;
	logic [31:0] gsel2_q;
	logic [`RTR_STAT_W-1:0] stat_sync1_q;
	logic [`RTR_STAT_W-1:0] stat_sync2_q;
	logic [`RTR_STAT_W-1:0] activity_q;
	logic [`RTR_STAT_W-1:0] activity_d;
	logic [`RTR_STAT_W-1:0] stat_live;
	logic [31:0] rdata_d;
	logic [NUM_PWM-1:0] pwm_a_route_select;
	rtr_src_t src;
	rtr_pwm_trig_t comb;
	rtr_route_t c1_route;
	rtr_route_t c2_route;
	rtr_grp_sel_t c1_sel;
	rtr_grp_sel_t c2_sel;

	function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
		input logic [7:0] ofs);
		return wr && (addr == ofs);
	endfunction

	function automatic rtr_grp_sel_t gsel_fields(input logic [31:0] w);
		rtr_grp_sel_t s;
		s.event_group_trigger_sel = w[`RTR_GSEL_EV_LSB +: `RTR_GSEL_W];
		s.group1_trigger_sel = w[`RTR_GSEL_G1_LSB +: `RTR_GSEL_W];
		s.group2_trigger_sel = w[`RTR_GSEL_G2_LSB +: `RTR_GSEL_W];
		return s;
	endfunction

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			route0_q <= `RTR_RST_ROUTE0;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_ROUTE0)) begin
			route0_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			route1_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_ROUTE1)) begin
			route1_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			route2_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_ROUTE2)) begin
			route2_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwmsel0_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_PWMSEL0)) begin
			pwmsel0_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwmsel1_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_PWMSEL1)) begin
			pwmsel1_q <= reg_wdata_in;
		end
	end

	// group selects: software moves them off code 000 (event 1, the pad) to stop a remuxed pad triggering
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gsel1_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_GSEL1)) begin
			gsel1_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gsel2_q <= `RTR_RST_ZERO;
		end else if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_GSEL2)) begin
			gsel2_q <= reg_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// routing controls
	// ------------------------------------------------------------
	always_comb begin
		c1_route.default_en = route0_q[`RTR_DEF_BIT];
		c1_route.alt_en = route0_q[`RTR_ALT_BIT];
		c1_route.opt_a = {route1_q[`RTR_C1_E8_POS], route1_q[`RTR_C1_E7_POS],
			route0_q[`RTR_C1_E6_POS], route0_q[`RTR_C1_E4_POS],
			route0_q[`RTR_C1_E2_POS]};
		c1_route.opt_b = {route1_q[`RTR_C1_E8_POS + 1], route1_q[`RTR_C1_E7_POS + 1],
			route0_q[`RTR_C1_E6_POS + 1], route0_q[`RTR_C1_E4_POS + 1],
			route0_q[`RTR_C1_E2_POS + 1]};
		// converter 2 shares the set choice but owns its option pairs
		c2_route.default_en = route0_q[`RTR_DEF_BIT];
		c2_route.alt_en = route0_q[`RTR_ALT_BIT];
		c2_route.opt_a = {route2_q[`RTR_C2_E8_POS], route2_q[`RTR_C2_E7_POS],
			route2_q[`RTR_C2_E6_POS], route1_q[`RTR_C2_E4_POS],
			route1_q[`RTR_C2_E2_POS]};
		c2_route.opt_b = {route2_q[`RTR_C2_E8_POS + 1], route2_q[`RTR_C2_E7_POS + 1],
			route2_q[`RTR_C2_E6_POS + 1], route1_q[`RTR_C2_E4_POS + 1],
			route1_q[`RTR_C2_E2_POS + 1]};
	end

	always_comb begin
		pwm_a_route_select = '0;
		pwm_a_route_select[0] = pwmsel0_q[`RTR_PWM_SEL_P0];
		pwm_a_route_select[1] = pwmsel0_q[`RTR_PWM_SEL_P1];
		pwm_a_route_select[2] = pwmsel0_q[`RTR_PWM_SEL_P2];
		pwm_a_route_select[3] = pwmsel0_q[`RTR_PWM_SEL_P3];
		pwm_a_route_select[4] = pwmsel1_q[`RTR_PWM_SEL_P0];
		pwm_a_route_select[5] = pwmsel1_q[`RTR_PWM_SEL_P1];
		pwm_a_route_select[6] = pwmsel1_q[`RTR_PWM_SEL_P2];
	end

	assign c1_sel = gsel_fields(gsel1_q);
	assign c2_sel = gsel_fields(gsel2_q);

	// ------------------------------------------------------------
	// trigger paths
	// ------------------------------------------------------------
	// sources are used raw; the sequencers edge-detect and synchronise
	always_comb begin
		src.timer1_channels = timer1_channels_in;
		src.timer2_channels = timer2_channels_in;
		src.rti_compare0 = rti_compare0_in;
		src.port_b_bits = port_b_bits_in;
	end

	rtr_pwm_combine #(
		.NUM_PWM(NUM_PWM)
	) u_combine (
		.pwm_conv_start_a_in(pwm_conv_start_a_in),
		.pwm_conv_start_b_in(pwm_conv_start_b_in),
		.pwm_a_route_select_in(pwm_a_route_select),
		.comb_out(comb)
	);

	rtr_conv_select u_conv1 (
		.event_pad_in(conv1_event_pad_in),
		.src_in(src),
		.pwm_in(comb),
		.route_in(c1_route),
		.sel_in(c1_sel),
		.group_trig_out(conv1_group_trig_out)
	);

	rtr_conv_select u_conv2 (
		.event_pad_in(conv2_event_pad_in),
		.src_in(src),
		.pwm_in(comb),
		.route_in(c2_route),
		.sel_in(c2_sel),
		.group_trig_out(conv2_group_trig_out)
	);

	// ------------------------------------------------------------
	// status observation
	// ------------------------------------------------------------
	// only the readback path is synchronised, the trigger path stays raw
	// status therefore lags the trigger outputs by two to three cycles
	always_comb begin
		stat_live = '0;
		stat_live[`RTR_STAT_C1_LSB +: 3] = conv1_group_trig_out;
		stat_live[`RTR_STAT_C2_LSB +: 3] = conv2_group_trig_out;
		stat_live[`RTR_STAT_PWM_LSB] = comb.combined_ab_trigger;
		stat_live[`RTR_STAT_PWM_LSB + 1] = comb.combined_a2_trigger;
		stat_live[`RTR_STAT_PWM_LSB + 2] = comb.combined_a1_trigger;
		stat_live[`RTR_STAT_PWM_LSB + 3] = comb.combined_b_trigger;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat_sync1_q <= '0;
		end else begin
			stat_sync1_q <= stat_live;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat_sync2_q <= '0;
		end else begin
			stat_sync2_q <= stat_sync1_q;
		end
	end

	// sticky activity, write one to clear; a new level wins over the clear
	always_comb begin
		activity_d = activity_q;
		if (wr_hit(reg_wr_in, reg_addr_in, `RTR_OFS_ACTIVITY)) begin
			activity_d = activity_d & ~reg_wdata_in[`RTR_STAT_W-1:0];
		end
		activity_d = activity_d | stat_sync2_q;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			activity_q <= '0;
		end else begin
			activity_q <= activity_d;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_addr_in == `RTR_OFS_ROUTE0) begin
			rdata_d = route0_q;
		end else if (reg_addr_in == `RTR_OFS_ROUTE1) begin
			rdata_d = route1_q;
		end else if (reg_addr_in == `RTR_OFS_ROUTE2) begin
			rdata_d = route2_q;
		end else if (reg_addr_in == `RTR_OFS_PWMSEL0) begin
			rdata_d = pwmsel0_q;
		end else if (reg_addr_in == `RTR_OFS_PWMSEL1) begin
			rdata_d = pwmsel1_q;
		end else if (reg_addr_in == `RTR_OFS_GSEL1) begin
			rdata_d = gsel1_q;
		end else if (reg_addr_in == `RTR_OFS_GSEL2) begin
			rdata_d = gsel2_q;
		end else if (reg_addr_in == `RTR_OFS_STATUS) begin
			rdata_d = {{(32-`RTR_STAT_W){1'b0}}, stat_sync2_q};
		end else if (reg_addr_in == `RTR_OFS_ACTIVITY) begin
			rdata_d = {{(32-`RTR_STAT_W){1'b0}}, activity_q};
		end
	end

	// data stands one cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end else begin
			reg_rdata_out <= 32'h0000_0000;
		end
	end

endmodule // rtr_router

//--- testbench/rtr_router_props.sv
`timescale 1ns/10ps
`include "rtr_defines.svh"
module rtr_router_props #(
	parameter int NUM_PWM = 7
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic conv1_event_pad_in,
	input wire logic conv2_event_pad_in,
	input wire logic [31:0] timer1_channels_in,
	input wire logic [17:0] timer2_channels_in,
	input wire logic rti_compare0_in,
	input wire logic [1:0] port_b_bits_in,
	input wire logic [NUM_PWM-1:0] pwm_conv_start_a_in,
	input wire logic [NUM_PWM-1:0] pwm_conv_start_b_in,
	input wire logic [2:0] conv1_group_trig_out,
	input wire logic [2:0] conv2_group_trig_out
);
	// ------------------------------------------------------------
	// shadows of the config words, taken off the bus
	// ------------------------------------------------------------
	logic [31:0] r0_q, r1_q, g1_q, g2_q, p0_q, p1_q;
	logic [6:0] sel;
	logic c_b, c_a1, c_a2;
	logic [7:0] dflt1, dflt2;
	logic [5:0] alt1;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r0_q <= `RTR_RST_ROUTE0;
			r1_q <= `RTR_RST_ZERO;
			g1_q <= `RTR_RST_ZERO;
			g2_q <= `RTR_RST_ZERO;
			p0_q <= `RTR_RST_ZERO;
			p1_q <= `RTR_RST_ZERO;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `RTR_OFS_ROUTE0) r0_q <= reg_wdata_in;
			if (reg_addr_in == `RTR_OFS_ROUTE1) r1_q <= reg_wdata_in;
			if (reg_addr_in == `RTR_OFS_GSEL1) g1_q <= reg_wdata_in;
			if (reg_addr_in == `RTR_OFS_GSEL2) g2_q <= reg_wdata_in;
			if (reg_addr_in == `RTR_OFS_PWMSEL0) p0_q <= reg_wdata_in;
			if (reg_addr_in == `RTR_OFS_PWMSEL1) p1_q <= reg_wdata_in;
		end
	end
	assign sel = {p1_q[16], p1_q[8], p1_q[0], p0_q[24], p0_q[16], p0_q[8], p0_q[0]};
	assign c_b = |pwm_conv_start_b_in;
	assign c_a1 = |(pwm_conv_start_a_in & ~sel);
	assign c_a2 = |(pwm_conv_start_a_in & sel);
	assign dflt1 = {port_b_bits_in, timer1_channels_in[14], timer1_channels_in[12],
		rti_compare0_in, timer1_channels_in[10], timer1_channels_in[8], conv1_event_pad_in};
	assign dflt2 = {dflt1[7:1], conv2_event_pad_in};
	// event 8 needs the second route word too, left to the bench
	assign alt1 = {r0_q[24] ? timer1_channels_in[19] : r0_q[25] & timer2_channels_in[1],
		timer1_channels_in[17], r0_q[16] ? rti_compare0_in : r0_q[17] & c_a1,
		timer1_channels_in[27], r0_q[8] ? timer2_channels_in[5] : r0_q[9] & c_b,
		conv1_event_pad_in};
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	sequence s_rd_gsel1;
		reg_rd_in && reg_addr_in == `RTR_OFS_GSEL1;
	endsequence
	sequence s_alt_set;
		r0_q[1:0] == 2'h2;
	endsequence
	a_def_event: assert property (r0_q[0] |-> conv1_group_trig_out[0] == dflt1[g1_q[2:0]])
		else $error("event group default route wrong");
	a_def_grp1: assert property (r0_q[0] |-> conv1_group_trig_out[1] == dflt1[g1_q[10:8]])
		else $error("group 1 default route wrong");
	a_def_grp2: assert property (r0_q[0] |-> conv1_group_trig_out[2] == dflt1[g1_q[18:16]])
		else $error("group 2 default route wrong");
	a_def_conv2: assert property (r0_q[0] |-> conv2_group_trig_out[0] == dflt2[g2_q[2:0]])
		else $error("second converter route wrong");
	a_alt_event: assert property (s_alt_set and g1_q[2:0] < 3'h6
		|-> conv1_group_trig_out[0] == alt1[g1_q[2:0]])
		else $error("event group alternate route wrong");
	a_alt_grp1: assert property (s_alt_set and g1_q[10:8] < 3'h6
		|-> conv1_group_trig_out[1] == alt1[g1_q[10:8]])
		else $error("group 1 alternate route wrong");
	a_alt_ev7: assert property (s_alt_set and g1_q[2:0] == 3'h6
		|-> conv1_group_trig_out[0] == (r1_q[0] ? timer1_channels_in[11] : r1_q[1] & c_a2))
		else $error("event 7 alternate route wrong");
	a_route_off: assert property (r0_q[1:0] == 2'h0
		|-> conv1_group_trig_out == 3'h0 && conv2_group_trig_out == 3'h0)
		else $error("trigger with no route set");
	a_rd_back: assert property (s_rd_gsel1 |=> reg_rdata_out == $past(g1_q))
		else $error("select readback wrong");
endmodule // rtr_router_props

bind rtr_router rtr_router_props #(.NUM_PWM(NUM_PWM)) chk_u (
	.clk_in(clk_in),
	.arst_n_in(arst_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.conv1_event_pad_in(conv1_event_pad_in),
	.conv2_event_pad_in(conv2_event_pad_in),
	.timer1_channels_in(timer1_channels_in),
	.timer2_channels_in(timer2_channels_in),
	.rti_compare0_in(rti_compare0_in),
	.port_b_bits_in(port_b_bits_in),
	.pwm_conv_start_a_in(pwm_conv_start_a_in),
	.pwm_conv_start_b_in(pwm_conv_start_b_in),
	.conv1_group_trig_out(conv1_group_trig_out),
	.conv2_group_trig_out(conv2_group_trig_out)
);

//--- testbench/rtr_seq_model.sv
`timescale 1ns/10ps
module rtr_seq_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [2:0] trig_in,
	output logic [2:0][7:0] starts_out
);
	logic [2:0] sync1_q, sync2_q, prev_q;
	// raw trigger comes unsynchronised, so the group does its own two flops
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			prev_q <= 3'h0;
			starts_out <= '0;
		end else begin
			sync1_q <= trig_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			for (int i = 0; i < 3; i++) begin
				if (sync2_q[i] && !prev_q[i]) starts_out[i] <= starts_out[i] + 8'h01;
			end
		end
	end
endmodule // rtr_seq_model

//--- testbench/rtr_router_test.sv
`timescale 1ns/10ps
`include "rtr_defines.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module rtr_router_test;
	typedef struct packed {
		logic [31:0] r0;
		logic [3:0] r78;
		logic [2:0] code;
		logic [4:0] src;
		logic hit;
	} rtr_tb_row_t;
	localparam rtr_tb_row_t rows [29] = '{
		'{32'h1, 4'h0, 3'h0, 5'h00, 1'h1}, '{32'h1, 4'h0, 3'h1, 5'h01, 1'h1},
		'{32'h1, 4'h0, 3'h2, 5'h02, 1'h1}, '{32'h1, 4'h0, 3'h3, 5'h03, 1'h1},
		'{32'h1, 4'h0, 3'h4, 5'h04, 1'h1}, '{32'h1, 4'h0, 3'h5, 5'h05, 1'h1},
		'{32'h1, 4'h0, 3'h6, 5'h06, 1'h1}, '{32'h1, 4'h0, 3'h7, 5'h07, 1'h1},
		'{32'h1, 4'h0, 3'h1, 5'h08, 1'h0}, '{32'h3, 4'h0, 3'h1, 5'h01, 1'h1},
		'{32'h01010102, 4'h0, 3'h0, 5'h00, 1'h1}, '{32'h01010102, 4'h0, 3'h1, 5'h08, 1'h1},
		'{32'h01010102, 4'h0, 3'h2, 5'h09, 1'h1}, '{32'h01010102, 4'h0, 3'h3, 5'h03, 1'h1},
		'{32'h01010102, 4'h0, 3'h4, 5'h0A, 1'h1}, '{32'h01010102, 4'h0, 3'h5, 5'h0B, 1'h1},
		'{32'h01010102, 4'h5, 3'h6, 5'h0C, 1'h1}, '{32'h01010102, 4'h5, 3'h7, 5'h0D, 1'h1},
		'{32'h02020202, 4'hA, 3'h1, 5'h0F, 1'h1}, '{32'h02020202, 4'hA, 3'h3, 5'h10, 1'h1},
		'{32'h02020202, 4'hA, 3'h3, 5'h11, 1'h0}, '{32'h02020202, 4'hA, 3'h5, 5'h0E, 1'h1},
		'{32'h02020202, 4'hA, 3'h6, 5'h11, 1'h1}, '{32'h02020202, 4'hA, 3'h6, 5'h12, 1'h1},
		'{32'h02020202, 4'hA, 3'h7, 5'h0F, 1'h1}, '{32'h02020202, 4'hA, 3'h7, 5'h11, 1'h1},
		'{32'h03030302, 4'hF, 3'h1, 5'h0F, 1'h0}, '{32'h2, 4'h0, 3'h1, 5'h08, 1'h0},
		'{32'h0, 4'h0, 3'h0, 5'h00, 1'h0}};
	logic clk_in, arst_n_in, reg_wr, reg_rd, pad1, pad2, rti;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, rdata, t1, rd_val;
	logic [17:0] t2;
	logic [1:0] pb;
	logic [6:0] pa, pbb;
	logic [18:0] src_q;
	logic [2:0] trig1, trig2;
	logic [2:0][7:0] starts1, starts2;
	int mismatches, n_checks;
	rtr_router #(.NUM_PWM(7)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(rdata), .conv1_event_pad_in(pad1),
		.conv2_event_pad_in(pad2), .timer1_channels_in(t1), .timer2_channels_in(t2),
		.rti_compare0_in(rti), .port_b_bits_in(pb), .pwm_conv_start_a_in(pa),
		.pwm_conv_start_b_in(pbb), .conv1_group_trig_out(trig1), .conv2_group_trig_out(trig2));
	rtr_seq_model seq1_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .trig_in(trig1),
		.starts_out(starts1));
	rtr_seq_model seq2_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .trig_in(trig2),
		.starts_out(starts2));
	always #20 clk_in = ~clk_in;
	// ------------------------------------------------------------
	// one-hot source index to the event inputs
	// ------------------------------------------------------------
	always_comb begin
		t1 = 32'h0;
		t2 = 18'h0;
		pa = 7'h0;
		pbb = 7'h0;
		pad1 = src_q[0];
		pad2 = src_q[0];
		t1[8] = src_q[1];
		t1[10] = src_q[2];
		rti = src_q[3];
		t1[12] = src_q[4];
		t1[14] = src_q[5];
		pb = src_q[7:6];
		t2[5] = src_q[8];
		t1[27] = src_q[9];
		t1[17] = src_q[10];
		t1[19] = src_q[11];
		t1[11] = src_q[12];
		t2[13] = src_q[13];
		t2[1] = src_q[14];
		pbb[6] = src_q[15];
		pa[1] = src_q[16];
		pa[0] = src_q[17];
		pa[6] = src_q[18];
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1 rd_val = rdata;
	endtask
	task automatic do_reset();
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
	endtask
	task automatic cfg(input rtr_tb_row_t r);
		wr(`RTR_OFS_ROUTE0, r.r0);
		wr(`RTR_OFS_ROUTE1, {6'h0, r.r0[17:16], 6'h0, r.r0[9:8], 6'h0, r.r78[3:2], 6'h0, r.r78[1:0]});
		wr(`RTR_OFS_ROUTE2, {14'h0, r.r78[3:2], 6'h0, r.r78[1:0], 6'h0, r.r0[25:24]});
		wr(`RTR_OFS_GSEL1, {13'h0, r.code, 5'h0, r.code, 5'h0, r.code});
		wr(`RTR_OFS_GSEL2, {13'h0, r.code, 5'h0, r.code, 5'h0, r.code});
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// no wait below is open-ended; this only cuts a hung run short
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
	initial begin
		clk_in = 1'b0;
		arst_n_in = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		src_q = 19'h0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		// out of reset every group follows its own pad
		src_q <= 19'h00001;
		@(posedge clk_in);
		#1 `CHK({trig1, trig2}, 6'h3F)
		repeat (2) @(posedge clk_in);
		src_q <= 19'h0;
		repeat (4) @(posedge clk_in);
		#1 `CHK({starts1, starts2}, 48'h010101010101)
		rd(`RTR_OFS_ROUTE0);
		`CHK(rd_val, 32'h1)
		wr(`RTR_OFS_GSEL1, 32'hFFFF_FFFF);
		rd(`RTR_OFS_GSEL1);
		`CHK(rd_val, 32'hFFFF_FFFF)
		wr(8'h24, 32'h5A5A_5A5A);
		rd(8'h24);
		`CHK(rd_val, 32'h0)
		wr(`RTR_OFS_PWMSEL0, 32'h0000_0001);
		wr(`RTR_OFS_PWMSEL1, 32'h0001_0000);
		foreach (rows[i]) begin
			cfg(rows[i]);
			src_q <= 19'h00001 << rows[i].src;
			@(posedge clk_in);
			#1 `CHK(trig1, {3{rows[i].hit}})
			`CHK(trig2, {3{rows[i].hit}})
			@(posedge clk_in);
			src_q <= 19'h0;
		end
		// status and sticky activity: pad plus pwm B start on the default set
		wr(`RTR_OFS_ROUTE0, 32'h0000_0001);
		wr(`RTR_OFS_ACTIVITY, 32'h0000_03FF);
		src_q <= 19'h08001;
		repeat (4) @(posedge clk_in);
		rd(`RTR_OFS_STATUS);
		`CHK(rd_val, 32'h0000_027F)
		rd(`RTR_OFS_ACTIVITY);
		`CHK(rd_val, 32'h0000_027F)
		// a clear under a live level loses to the set
		wr(`RTR_OFS_ACTIVITY, 32'h0000_03FF);
		rd(`RTR_OFS_ACTIVITY);
		`CHK(rd_val, 32'h0000_027F)
		src_q <= 19'h0;
		repeat (4) @(posedge clk_in);
		wr(`RTR_OFS_ACTIVITY, 32'h0000_0040);
		rd(`RTR_OFS_ACTIVITY);
		`CHK(rd_val, 32'h0000_023F)
		rd(`RTR_OFS_STATUS);
		`CHK(rd_val, 32'h0000_0000)
		// converter 2 takes option B of event 2 while converter 1 takes A
		wr(`RTR_OFS_ROUTE0, 32'h0000_0102);
		wr(`RTR_OFS_ROUTE1, 32'h0002_0000);
		wr(`RTR_OFS_GSEL1, 32'h0000_0001);
		wr(`RTR_OFS_GSEL2, 32'h0000_0001);
		src_q <= 19'h00100;
		@(posedge clk_in);
		#1 `CHK({trig1[0], trig2[0]}, 2'h2)
		src_q <= 19'h08000;
		@(posedge clk_in);
		#1 `CHK({trig1[0], trig2[0]}, 2'h1)
		src_q <= 19'h0;
		// a second reset in mid-run restores the default set
		do_reset();
		rd(`RTR_OFS_ROUTE0);
		`CHK(rd_val, 32'h1)
		rd(`RTR_OFS_GSEL2);
		`CHK(rd_val, 32'h0)
		finish_test();
	end
endmodule // rtr_router_test
